//--- src/acmsp_port.v
/*
 * Serial peripheral slave port of a three-axis acceleration sensor
 * with its register map. The link clock is sampled by clk_sys and
 * its edges found here; it must be slower than a quarter of clk_sys.
 * Assumes the measurement chain supplies samples, status and event
 * sources, and takes the control registers and strobes given out.
 * Assumes chip select stays high for at least four clk_sys cycles
 * between frames and the interface-mode bit changes only between
 * frames. Read bytes are fetched one block ahead, so a source
 * strobe fires when its byte is loaded, even if the master ends
 * the frame before clocking it out.
 */
`timescale 1ns/100ps
`include "acmsp_regs.vh"

// Functional notes
// - Drive on falling, sample on rising edge
// - Sixteen periods plus whole eight-period blocks
// - Bit zero starts at first falling edge
// - Direction bit; read data driven from bit eight
// - Increment flag chooses fixed or advancing index
// - Six-bit register index, MSB first
// - One data byte, MSB first
// - Each extra block carries one more byte
// - Interface-mode bit set selects three-wire
// - Three-wire mode keeps single and multi reads
// - Register map at documented indices
// - Trim reload at power-up, boot-loaded untouched
// - Mode bit zero uses separate output pin
// - Three-wire read data on shared pin
module acmsp_port (
	input  wire       clk_sys,
	input  wire       srst,
	// Serial link pins
	input  wire       chip_select_n,
	input  wire       serial_port_clock,
	input  wire       serial_data_in,
	output wire       serial_data_in_drive,
	output wire       serial_data_in_oe,
	output wire       serial_data_out,
	output wire       serial_data_out_oe,
	// Measurement chain side
	input  wire [7:0] sample_status,
	input  wire [7:0] x_axis_sample,
	input  wire [7:0] y_axis_sample,
	input  wire [7:0] z_axis_sample,
	input  wire [7:0] motion_event_source_a,
	input  wire [7:0] motion_event_source_b,
	output reg  [7:0] control_one,
	output wire [7:0] control_two,
	output reg  [7:0] control_three,
	output reg  [7:0] motion_event_config_a,
	output reg  [7:0] motion_event_threshold_a,
	output reg  [7:0] motion_event_duration_a,
	output reg  [7:0] motion_event_config_b,
	output reg  [7:0] motion_event_threshold_b,
	output reg  [7:0] motion_event_duration_b,
	output reg        trim_reload,
	output reg        highpass_reset_strobe,
	output reg        source_a_read_strobe,
	output reg        source_b_read_strobe
);

	// Synchronised pins and link clock edges
	wire [2:0] pins_sync;
	wire       cs_n_s;
	wire       sclk_s;
	wire       sdi_s;
	reg        sclk_d;
	wire       sclk_rise;
	wire       sclk_fall;
	wire       frame_active;

	// Receive side and command decode
	reg  [6:0] rx_shift;
	wire [7:0] rx_byte;
	reg  [2:0] bit_pos;
	reg        cmd_done;
	reg        dir_read;
	reg        index_increment_flag;
	reg  [5:0] reg_index;
	wire [5:0] next_index;
	wire       byte_end;
	wire       load_read;

	// Transmit side and pin enables
	reg  [5:0] read_addr;
	reg  [7:0] read_data;
	reg  [7:0] tx_shift;
	reg        tx_bit;
	reg        drive_dedicated;
	reg        drive_shared;

	// Register state
	reg  [7:0] control_two_store;
	reg        boot_pending;
	wire       three_wire_select;

	// Pins cross into clk_sys through two flip-flops
	acmsp_sync #(
		.WIDTH   (3),
		.RST_VAL (3'h7)
	) u_sync (
		.clk_sys  (clk_sys),
		.srst     (srst),
		.async_in ({chip_select_n, serial_port_clock, serial_data_in}),
		.sync_out (pins_sync)
	);

	assign cs_n_s = pins_sync[2];
	assign sclk_s = pins_sync[1];
	assign sdi_s  = pins_sync[0];

	// Edge detector on the synchronised link clock
	always @(posedge clk_sys) begin
		if (srst) begin
			sclk_d <= 1'b1;
		end else begin
			sclk_d <= sclk_s;
		end
	end

	// Frame and link clock edges, gated by chip select
	assign frame_active = ~cs_n_s;
	assign sclk_rise    = frame_active & sclk_s & ~sclk_d;
	assign sclk_fall    = frame_active & ~sclk_s & sclk_d;

	// Received byte and the rising edge that ends it
	assign rx_byte      = {rx_shift, sdi_s};
	assign byte_end     = sclk_rise & (bit_pos == `ACMSP_BYTE_LAST_BIT);

	// Byte to load for reading: after a read command, then every block
	assign load_read    = byte_end & (cmd_done ? dir_read : rx_byte[`ACMSP_CMD_DIR_BIT]);

	// Index of the next block, fixed or advancing
	assign next_index = index_increment_flag ? reg_index + 6'h01 : reg_index;

	// Mode bit and boot status as seen by software
	assign three_wire_select = control_two_store[`ACMSP_BIT_THREE_WIRE];
	assign control_two = {control_two_store[7], boot_pending, control_two_store[5:0]};

	// Address of the byte to load for the coming read block
	always @* begin
		if (cmd_done) begin
			read_addr = next_index;
		end else begin
			read_addr = rx_byte[5:0];
		end
	end

	// Read multiplexer over the register map
	always @* begin
		case (read_addr)
		`ACMSP_IDX_DEVICE_IDENTITY: read_data = `ACMSP_IDENTITY_VALUE;
		`ACMSP_IDX_CONTROL_ONE:     read_data = control_one;
		`ACMSP_IDX_CONTROL_TWO:     read_data = control_two;
		`ACMSP_IDX_CONTROL_THREE:   read_data = control_three;
		`ACMSP_IDX_HIGHPASS_RESET:  read_data = `ACMSP_RST_DUMMY;
		`ACMSP_IDX_SAMPLE_STATUS:   read_data = sample_status;
		`ACMSP_IDX_X_AXIS_SAMPLE:   read_data = x_axis_sample;
		`ACMSP_IDX_Y_AXIS_SAMPLE:   read_data = y_axis_sample;
		`ACMSP_IDX_Z_AXIS_SAMPLE:   read_data = z_axis_sample;
		`ACMSP_IDX_EVENT_CONFIG_A:  read_data = motion_event_config_a;
		`ACMSP_IDX_EVENT_SOURCE_A:  read_data = motion_event_source_a;
		`ACMSP_IDX_EVENT_THRESH_A:  read_data = motion_event_threshold_a;
		`ACMSP_IDX_EVENT_DUR_A:     read_data = motion_event_duration_a;
		`ACMSP_IDX_EVENT_CONFIG_B:  read_data = motion_event_config_b;
		`ACMSP_IDX_EVENT_SOURCE_B:  read_data = motion_event_source_b;
		`ACMSP_IDX_EVENT_THRESH_B:  read_data = motion_event_threshold_b;
		`ACMSP_IDX_EVENT_DUR_B:     read_data = motion_event_duration_b;
		default:                    read_data = 8'h00;
		endcase
	end

	// Command decode, bit counting and receive shifting
	always @(posedge clk_sys) begin
		if (srst) begin
			rx_shift             <= 7'h00;
			bit_pos              <= 3'h0;
			cmd_done             <= 1'b0;
			dir_read             <= 1'b0;
			index_increment_flag <= 1'b0;
			reg_index            <= 6'h00;
		end else if (!frame_active) begin
			bit_pos  <= 3'h0;
			cmd_done <= 1'b0;
		end else if (sclk_rise) begin
			rx_shift <= rx_byte[6:0];
			bit_pos  <= bit_pos + 3'h1;
			if (bit_pos == `ACMSP_BYTE_LAST_BIT) begin
				cmd_done <= 1'b1;
				if (!cmd_done) begin
					dir_read             <= rx_byte[`ACMSP_CMD_DIR_BIT];
					index_increment_flag <= rx_byte[`ACMSP_CMD_INC_BIT];
					reg_index            <= rx_byte[5:0];
				end else begin
					reg_index <= next_index;
				end
			end
		end
	end

	// Read data shifting, launched on falling edges from bit eight
	always @(posedge clk_sys) begin
		if (srst) begin
			tx_shift <= 8'h00;
			tx_bit   <= 1'b0;
		end else if (load_read) begin
			tx_shift <= read_data;
		end else if (sclk_fall && cmd_done && dir_read) begin
			tx_bit   <= tx_shift[7];
			tx_shift <= {tx_shift[6:0], 1'b0};
		end
	end

	// Pin enables from flip-flops, steered by the mode bit
	always @(posedge clk_sys) begin
		if (srst) begin
			drive_dedicated <= 1'b0;
			drive_shared    <= 1'b0;
		end else if (!frame_active) begin
			drive_dedicated <= 1'b0;
			drive_shared    <= 1'b0;
		end else if (sclk_fall && cmd_done && dir_read) begin
			drive_dedicated <= ~three_wire_select;
			drive_shared    <= three_wire_select;
		end
	end

	// Strobes to the measurement chain when a read byte is loaded
	always @(posedge clk_sys) begin
		if (srst) begin
			highpass_reset_strobe <= 1'b0;
			source_a_read_strobe  <= 1'b0;
			source_b_read_strobe  <= 1'b0;
		end else begin
			highpass_reset_strobe <= 1'b0;
			source_a_read_strobe  <= 1'b0;
			source_b_read_strobe  <= 1'b0;
			if (load_read) begin
				highpass_reset_strobe <= (read_addr == `ACMSP_IDX_HIGHPASS_RESET);
				source_a_read_strobe  <= (read_addr == `ACMSP_IDX_EVENT_SOURCE_A);
				source_b_read_strobe  <= (read_addr == `ACMSP_IDX_EVENT_SOURCE_B);
			end
		end
	end

	// Register writes; read-only and reserved indices fall through
	always @(posedge clk_sys) begin
		if (srst) begin
			control_one              <= `ACMSP_RST_CONTROL_ONE;
			control_two_store        <= `ACMSP_RST_CONTROL_TWO;
			control_three            <= `ACMSP_RST_CONTROL_THREE;
			motion_event_config_a    <= `ACMSP_RST_EVENT;
			motion_event_threshold_a <= `ACMSP_RST_EVENT;
			motion_event_duration_a  <= `ACMSP_RST_EVENT;
			motion_event_config_b    <= `ACMSP_RST_EVENT;
			motion_event_threshold_b <= `ACMSP_RST_EVENT;
			motion_event_duration_b  <= `ACMSP_RST_EVENT;
		end else if (byte_end && cmd_done && !dir_read) begin
			case (reg_index)
			`ACMSP_IDX_CONTROL_ONE:    control_one              <= rx_byte;
			`ACMSP_IDX_CONTROL_TWO:    control_two_store        <= rx_byte;
			`ACMSP_IDX_CONTROL_THREE:  control_three            <= rx_byte;
			`ACMSP_IDX_EVENT_CONFIG_A: motion_event_config_a    <= rx_byte;
			`ACMSP_IDX_EVENT_THRESH_A: motion_event_threshold_a <= rx_byte;
			`ACMSP_IDX_EVENT_DUR_A:    motion_event_duration_a  <= rx_byte;
			`ACMSP_IDX_EVENT_CONFIG_B: motion_event_config_b    <= rx_byte;
			`ACMSP_IDX_EVENT_THRESH_B: motion_event_threshold_b <= rx_byte;
			`ACMSP_IDX_EVENT_DUR_B:    motion_event_duration_b  <= rx_byte;
			default: ;
			endcase
		end
	end

	// Trim reload after reset and on a boot request; bit self-clears
	always @(posedge clk_sys) begin
		if (srst) begin
			boot_pending <= 1'b1;
			trim_reload  <= 1'b0;
		end else if (byte_end && cmd_done && !dir_read &&
			     reg_index == `ACMSP_IDX_CONTROL_TWO &&
			     rx_byte[`ACMSP_BIT_BOOT]) begin
			boot_pending <= 1'b1;
			trim_reload  <= 1'b0;
		end else begin
			boot_pending <= 1'b0;
			trim_reload  <= boot_pending;
		end
	end

	// Pin steering by the interface-mode bit
	assign serial_data_out      = tx_bit;
	assign serial_data_out_oe   = drive_dedicated;
	assign serial_data_in_drive = tx_bit;
	assign serial_data_in_oe    = drive_shared;

endmodule // acmsp_port

//--- src/acmsp_regs.vh
/*
 * Register indices, field positions and reset values of the
 * acceleration sensor serial register port.
 * Included by the port's top design file and by its testbench.
 */
`ifndef ACMSP_REGS_VH
`define ACMSP_REGS_VH

// Register indices on the serial port, six bits wide
`define ACMSP_IDX_DEVICE_IDENTITY   6'h0f
`define ACMSP_IDX_CONTROL_ONE       6'h20
`define ACMSP_IDX_CONTROL_TWO       6'h21
`define ACMSP_IDX_CONTROL_THREE     6'h22
`define ACMSP_IDX_HIGHPASS_RESET    6'h23
`define ACMSP_IDX_SAMPLE_STATUS     6'h27
`define ACMSP_IDX_X_AXIS_SAMPLE     6'h29
`define ACMSP_IDX_Y_AXIS_SAMPLE     6'h2b
`define ACMSP_IDX_Z_AXIS_SAMPLE     6'h2d
`define ACMSP_IDX_EVENT_CONFIG_A    6'h30
`define ACMSP_IDX_EVENT_SOURCE_A    6'h31
`define ACMSP_IDX_EVENT_THRESH_A    6'h32
`define ACMSP_IDX_EVENT_DUR_A       6'h33
`define ACMSP_IDX_EVENT_CONFIG_B    6'h34
`define ACMSP_IDX_EVENT_SOURCE_B    6'h35
`define ACMSP_IDX_EVENT_THRESH_B    6'h36
`define ACMSP_IDX_EVENT_DUR_B       6'h37

// Reset values
`define ACMSP_RST_CONTROL_ONE       8'h07
`define ACMSP_RST_CONTROL_TWO       8'h00
`define ACMSP_RST_CONTROL_THREE     8'h00
`define ACMSP_RST_EVENT             8'h00
`define ACMSP_RST_DUMMY             8'h00

// Identity value, arbitrary
`define ACMSP_IDENTITY_VALUE        8'h5a

// Fields of control_two
`define ACMSP_BIT_THREE_WIRE        7
`define ACMSP_BIT_BOOT              6

// Command byte layout
`define ACMSP_CMD_DIR_BIT           7
`define ACMSP_CMD_INC_BIT           6

// Serial timing: last bit position in a byte, link clock period
`define ACMSP_BYTE_LAST_BIT         3'h7
`define ACMSP_LINK_CLK_PERIOD_NS    400

`endif

//--- src/acmsp_sync.v
/*
 * Two flip-flop synchroniser for a group of pin inputs.
 * Assumes the inputs are asynchronous to clk_sys; the outputs
 * are usable by any logic in the clk_sys domain.
 */
`timescale 1ns/100ps

module acmsp_sync #(
	parameter WIDTH   = 3,
	parameter RST_VAL = 3'h7
) (
	input  wire             clk_sys,
	input  wire             srst,
	input  wire [WIDTH-1:0] async_in,
	output wire [WIDTH-1:0] sync_out
);

	reg [WIDTH-1:0] stage_one;
	reg [WIDTH-1:0] stage_two;

	// First stage feeds only the second
	always @(posedge clk_sys) begin
		if (srst) begin
			stage_one <= RST_VAL;
			stage_two <= RST_VAL;
		end else begin
			stage_one <= async_in;
			stage_two <= stage_one;
		end
	end

	assign sync_out = stage_two;

endmodule // acmsp_sync

//--- testbench/acmsp_props.sv
/* Checker for the serial register port.
   Bound to acmsp_port and sees only its ports. */
`timescale 1ns/100ps
module acmsp_props (
	input wire       clk_sys,
	input wire       srst,
	input wire       chip_select_n,
	input wire       serial_port_clock,
	input wire       serial_data_in_oe,
	input wire       serial_data_out,
	input wire       serial_data_out_oe,
	input wire [7:0] control_one,
	input wire [7:0] control_two,
	input wire       trim_reload
);
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (srst);
	// Pin ownership and framing
	a_one_driver: assert property (!(serial_data_in_oe && serial_data_out_oe))
		else $error("both data pins driven");
	a_idle_release: assert property (chip_select_n [*5] |->
		!serial_data_in_oe && !serial_data_out_oe) else $error("pin driven when idle");
	a_shared_mode: assert property (serial_data_in_oe |-> control_two[7])
		else $error("shared pin driven in four-wire mode");
	a_oe_start: assert property ($rose(serial_data_in_oe || serial_data_out_oe) |->
		!chip_select_n && !$past(serial_port_clock, 2)) else $error("late or stray drive");
	a_out_on_fall: assert property (serial_data_out_oe && $past(serial_data_out_oe) &&
		$changed(serial_data_out) |-> !$past(serial_port_clock, 2))
		else $error("data changed off falling edge");
	// Reset, boot and write behaviour
	a_boot_reload: assert property ($fell(srst) |-> ##[0:2] trim_reload)
		else $error("no trim reload after reset");
	a_reset_vals: assert property ($fell(srst) |->
		control_one == 8'h07 && !control_two[7]) else $error("bad reset values");
	a_write_frame: assert property ($changed(control_one) |->
		!chip_select_n && serial_port_clock) else $error("write outside frame");
endmodule // acmsp_props

bind acmsp_port acmsp_props u_props (
	.clk_sys, .srst, .chip_select_n, .serial_port_clock, .serial_data_in_oe,
	.serial_data_out, .serial_data_out_oe, .control_one, .control_two, .trim_reload
);

//--- testbench/acmsp_master.sv
/* Serial link master model, mode 3, MSB first.
   Assumes clk_sys at 50 ns; link period is 8 cycles. */
`timescale 1ns/100ps
module acmsp_master (
	input  wire clk_sys,
	input  wire three_wire,
	input  wire shared_line,
	input  wire data_out,
	input  wire data_out_oe,
	output reg  chip_select_n,
	output reg  serial_port_clock,
	output reg  data_to_dev,
	output reg  data_to_dev_oe
);
	// Undriven dedicated pin shows the inverse of its last value
	wire rx = three_wire ? shared_line : (data_out_oe ? data_out : !data_out);
	initial begin
		chip_select_n = 1'b1;
		serial_port_clock = 1'b1;
		data_to_dev = 1'b0;
		data_to_dev_oe = 1'b0;
	end
	task half;
		repeat (4) @(negedge clk_sys);
	endtask
	// One frame: command byte then n whole data bytes
	task frame(input [7:0] cmd, input int n, input [31:0] wd, output [31:0] rd);
		int i;
		logic [39:0] sh;
		sh = {cmd, wd};
		rd = 0;
		chip_select_n <= 1'b0;
		half;
		for (i = 0; i < 8 * (n + 1); i++) begin
			serial_port_clock <= 1'b0;
			data_to_dev <= sh[39 - i];
			data_to_dev_oe <= !(cmd[7] && i > 7);
			half;
			serial_port_clock <= 1'b1;
			half;
			if (i > 7)
				rd = {rd[30:0], rx}; // Late in high phase, past synchroniser delay
		end
		half;
		chip_select_n <= 1'b1;
		data_to_dev_oe <= 1'b0;
		repeat (6) @(negedge clk_sys);
	endtask
endmodule // acmsp_master

//--- testbench/acmsp_port_tb.sv
/* Self-checking bench for acmsp_port.
   Drives inputs on falling clk_sys; master model on the link. */
`timescale 1ns/100ps
`include "acmsp_regs.vh"
module acmsp_port_tb;
	reg         clk_sys = 0;
	reg         srst = 1;
	reg         three_wire = 0;
	reg  [7:0]  sample_status = 8'h11, x_axis_sample = 8'h22, y_axis_sample = 8'h33;
	reg  [7:0]  z_axis_sample = 8'h44, motion_event_source_a = 0, motion_event_source_b = 0;
	reg  [31:0] rd;
	wire        chip_select_n, serial_port_clock, serial_data_in, m_do, m_oe;
	wire        serial_data_in_drive, serial_data_in_oe, serial_data_out, serial_data_out_oe;
	wire        trim_reload, highpass_reset_strobe, source_a_read_strobe, source_b_read_strobe;
	wire [7:0]  control_one, control_two, control_three;
	wire [7:0]  motion_event_config_a, motion_event_threshold_a, motion_event_duration_a;
	wire [7:0]  motion_event_config_b, motion_event_threshold_b, motion_event_duration_b;
	int         failures = 0;
	int         tests_run = 0;
	int         strobe_hp = 0, strobe_a = 0, strobe_b = 0;
	// Shared pin level; released line shows inverse of last value
	assign serial_data_in = serial_data_in_oe ? serial_data_in_drive : m_oe ? m_do : !m_do;
	always #25 clk_sys = !clk_sys;
	// Strobe pulses counted on falling clk_sys
	always @(negedge clk_sys) begin
		strobe_hp += (highpass_reset_strobe === 1'b1);
		strobe_a  += (source_a_read_strobe === 1'b1);
		strobe_b  += (source_b_read_strobe === 1'b1);
	end
	acmsp_port dut (
		.clk_sys, .srst, .chip_select_n, .serial_port_clock, .serial_data_in,
		.serial_data_in_drive, .serial_data_in_oe, .serial_data_out, .serial_data_out_oe,
		.sample_status, .x_axis_sample, .y_axis_sample, .z_axis_sample,
		.motion_event_source_a, .motion_event_source_b, .control_one, .control_two,
		.control_three, .motion_event_config_a, .motion_event_threshold_a,
		.motion_event_duration_a, .motion_event_config_b, .motion_event_threshold_b,
		.motion_event_duration_b, .trim_reload, .highpass_reset_strobe,
		.source_a_read_strobe, .source_b_read_strobe
	);
	acmsp_master m (
		.clk_sys(clk_sys), .three_wire(three_wire), .shared_line(serial_data_in),
		.data_out(serial_data_out), .data_out_oe(serial_data_out_oe),
		.chip_select_n(chip_select_n), .serial_port_clock(serial_port_clock),
		.data_to_dev(m_do), .data_to_dev_oe(m_oe)
	);
	task chk(input string nm, input [31:0] e, input [31:0] a);
		tests_run++;
		if (a !== e) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", nm, e, a);
		end
	endtask
	task conclude;
		$display("checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// Reset values, identity and status reads
	task t_reset;
		chk("ctl1", 8'h07, control_one);
		chk("ctl2", 8'h00, control_two);
		chk("evt", 0, {motion_event_config_b, motion_event_duration_b});
		m.frame({2'b10, `ACMSP_IDX_DEVICE_IDENTITY}, 1, 0, rd);
		chk("ident", `ACMSP_IDENTITY_VALUE, rd[7:0]);
		m.frame({2'b10, `ACMSP_IDX_SAMPLE_STATUS}, 1, 0, rd);
		chk("status", 8'h11, rd[7:0]);
	endtask
	// Single write then read back
	task t_single;
		m.frame({2'b00, `ACMSP_IDX_CONTROL_ONE}, 1, 32'ha5000000, rd);
		chk("ctl1 wr", 8'ha5, control_one);
		m.frame({2'b10, `ACMSP_IDX_CONTROL_ONE}, 1, 0, rd);
		chk("ctl1 rd", 8'ha5, rd[7:0]);
	endtask
	// Advancing index across a read-only slot
	task t_inc;
		m.frame({2'b01, `ACMSP_IDX_EVENT_CONFIG_A}, 4, 32'h12345678, rd);
		chk("thr a", 8'h56, motion_event_threshold_a);
		chk("dur a", 8'h78, motion_event_duration_a);
		motion_event_source_a = 8'h3c;
		m.frame({2'b11, `ACMSP_IDX_EVENT_CONFIG_A}, 4, 0, rd);
		chk("inc rd", 32'h123c5678, rd);
	endtask
	// Fixed index for every byte
	task t_fixed;
		m.frame({2'b00, `ACMSP_IDX_CONTROL_THREE}, 2, 32'h0ff00000, rd);
		chk("fixed wr", 8'hf0, control_three);
		m.frame({2'b10, `ACMSP_IDX_Z_AXIS_SAMPLE}, 2, 0, rd);
		chk("fixed rd", 16'h4444, rd[15:0]);
	endtask
	// Three-wire reads on the shared pin, unused slots read zero
	task t_three;
		m.frame({2'b00, `ACMSP_IDX_CONTROL_TWO}, 1, 32'h80000000, rd);
		three_wire = 1'b1;
		m.frame({2'b11, `ACMSP_IDX_X_AXIS_SAMPLE}, 4, 0, rd);
		chk("3w rd", 32'h22003300, rd);
		m.frame({2'b00, `ACMSP_IDX_CONTROL_TWO}, 1, 0, rd);
		three_wire = 1'b0;
		chk("ctl2 off", 8'h00, control_two);
	endtask
	// Boot bit gives exactly one reload pulse
	task t_boot;
		int k;
		k = 0;
		fork
			m.frame({2'b00, `ACMSP_IDX_CONTROL_TWO}, 1, 32'h40000000, rd);
			repeat (300) @(negedge clk_sys) k += (trim_reload === 1'b1);
		join
		chk("reload", 1, k);
	endtask
	// Bank b writes past a read-only slot; one strobe per loaded source
	task t_strobe;
		m.frame({2'b01, `ACMSP_IDX_EVENT_CONFIG_B}, 4, 32'h9a8b7c6d, rd);
		chk("cfg b", 8'h9a, motion_event_config_b);
		chk("thr dur b", 16'h7c6d, {motion_event_threshold_b, motion_event_duration_b});
		motion_event_source_b = 8'hc5;
		strobe_hp = 0;
		strobe_a  = 0;
		strobe_b  = 0;
		m.frame({2'b11, `ACMSP_IDX_HIGHPASS_RESET}, 1, 0, rd);
		chk("hp rd", `ACMSP_RST_DUMMY, rd[7:0]);
		m.frame({2'b11, `ACMSP_IDX_EVENT_SOURCE_A}, 1, 0, rd);
		chk("src a rd", 8'h3c, rd[7:0]);
		m.frame({2'b11, `ACMSP_IDX_EVENT_SOURCE_B}, 1, 0, rd);
		chk("src b rd", 8'hc5, rd[7:0]);
		chk("strobes", 24'h010101, {strobe_hp[7:0], strobe_a[7:0], strobe_b[7:0]});
	endtask
	initial begin
		repeat (2) @(negedge clk_sys);
		srst = 1'b0;
		repeat (4) @(negedge clk_sys);
		t_reset;
		t_single;
		t_inc;
		t_fixed;
		t_three;
		t_boot;
		t_strobe;
		conclude;
	end
	// Watchdog, several times the expected run length
	initial begin
		#1000000;
		failures++;
		conclude;
	end
endmodule // acmsp_port_tb
